// ===== shared/ptmr_pkg.sv
// Types for the printer test and message readback block
package ptmr_pkg;
   typedef enum logic [2:0]
   {
      PTMR_IDLE = 3'b000,
      PTMR_ASCII = 3'b001,
      PTMR_MSG_HDR = 3'b010,
      PTMR_MSG_BODY = 3'b011,
      PTMR_DONE = 3'b100
   } ptmr_state_e;
   typedef struct packed
   {
      logic valid;
      logic [7:0] data;
   } ptmr_char_s;
   typedef struct packed
   {
      logic wr;
      logic [11:0] addr;
      logic [15:0] wdata;
   } ptmr_bus_s;
endpackage : ptmr_pkg

// ===== shared/ptmr_regs.svh
// Offsets, codes, widths and limits for the printer test and message readback block
`ifndef PTMR_REGS_SVH
`define PTMR_REGS_SVH
`define PTMR_ADDR_W 12
`define PTMR_DATA_W 16
`define PTMR_FUNC_SEL_ADDR 12'h800
`define PTMR_FUNC_ERR_ADDR 12'h801
`define PTMR_FREE_BASE_ADDR 12'h900
`define PTMR_FREE_SLOT_WORDS 12'h029
`define PTMR_FREE_SLOTS 31
`define PTMR_FUNC_TEST_OUT 16'h0004
`define PTMR_FUNC_PRN_TEST 16'h0005
`define PTMR_CHAR_FIRST 8'h21
`define PTMR_CHAR_LAST 8'h7E
`define PTMR_MSG_LEN_MIN 16'h0001
`define PTMR_MSG_LEN_MAX 16'h0050
`define PTMR_ERR_NONE 16'h0000
`define PTMR_ERR_BAD_FUNC 16'h0001
`define PTMR_ERR_BAD_LEN 16'h0002
`define PTMR_ERR_NO_MSG 16'h0003
`endif

// ===== tb/ptmr_prn_model.sv
// Printer sink model that records every accepted character
`timescale 1ns/1ps
module ptmr_prn_model (
   input wire logic clk,
   input wire logic resetn,
   input wire ptmr_pkg::ptmr_char_s prn_char,
   input wire logic slow,
   output logic prn_ready
);
   logic tog_r;
   logic [7:0] got[$];

   // ****************************************
   // Ready pacing and capture
   // ****************************************
   // Slow mode stalls every other cycle so held characters are exercised
   assign prn_ready = slow ? tog_r : 1'b1;

   // One character taken per cycle where valid meets ready
   always @(posedge clk)
   begin
      if (!resetn)
      begin
         tog_r <= 1'b0;
      end
      else
      begin
         tog_r <= ~tog_r;
         if (prn_char.valid && prn_ready)
         begin
            got.push_back(prn_char.data);
         end
      end
   end
endmodule : ptmr_prn_model

// ===== tb/tb.sv
// Self-checking bench for the printer function engine
`timescale 1ns/1ps
`include "ptmr_regs.svh"
module tb;
   logic clk;
   logic resetn;
   ptmr_pkg::ptmr_bus_s host_bus;
   logic [15:0] host_rdata;
   logic print_req;
   logic print_done;
   ptmr_pkg::ptmr_char_s prn_char;
   logic prn_ready;
   logic slow;
   logic [15:0] rd_val;
   logic [7:0] exp_q[$];
   int num_errors;
   int total_checks;

   ptmr_core ptmr_core_inst (.clk(clk), .resetn(resetn), .host_bus(host_bus),
      .host_rdata(host_rdata), .print_req(print_req), .print_done(print_done),
      .prn_char(prn_char), .prn_ready(prn_ready));
   ptmr_prn_model ptmr_prn_model_inst (.clk(clk), .resetn(resetn), .prn_char(prn_char),
      .slow(slow), .prn_ready(prn_ready));

   // ****************************************
   // Clock
   // ****************************************
   // 50 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // ****************************************
   // Checking and bus tasks
   // ****************************************
   task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task end_of_test;
      if (num_errors == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_of_test

   // Write strobe lasts one cycle per word
   task wr(input logic [11:0] a, input logic [15:0] d);
      @(posedge clk);
      host_bus <= '{wr: 1'b1, addr: a, wdata: d};
      @(posedge clk);
      host_bus.wr <= 1'b0;
   endtask : wr

   // Read data is registered, so it lands one edge after the address
   task rd(input logic [11:0] a, output logic [15:0] v);
      @(posedge clk);
      host_bus.addr <= a;
      @(posedge clk);
      #1 v = host_rdata;
   endtask : rd

   // Count word then packed words, first character in the low byte
   task put_msg(input logic [11:0] slot, input string s);
      logic [11:0] base;
      logic [7:0] hi;
      base = `PTMR_FREE_BASE_ADDR + slot * `PTMR_FREE_SLOT_WORDS;
      wr(base, 16'(s.len()));
      for (int i = 0; i < s.len(); i += 2)
      begin
         hi = (i + 1 < s.len()) ? s[i + 1] : 8'h00;
         wr(base + 12'(1 + i / 2), {hi, s[i]});
      end
   endtask : put_msg

   task expect_str(input string s);
      exp_q.delete();
      for (int i = 0; i < s.len(); i++)
         exp_q.push_back(s[i]);
   endtask : expect_str

   // Select, request, wait for done, drop request, then check result and output
   task run(input logic [15:0] func, input logic [15:0] err, input bit poke);
      int n;
      wr(`PTMR_FUNC_SEL_ADDR, func);
      ptmr_prn_model_inst.got.delete();
      @(posedge clk);
      print_req <= 1'b1;
      if (poke)
      begin
         repeat (10) @(posedge clk);
         wr(`PTMR_FUNC_SEL_ADDR, `PTMR_FUNC_TEST_OUT);
      end
      n = 0;
      while (print_done !== 1'b1 && n < 20000)
      begin
         @(posedge clk);
         #1 n++;
      end
      if (n >= 20000)
      begin
         chk("done wait", 16'h0000, 16'h0001);
         end_of_test();
      end
      @(posedge clk);
      print_req <= 1'b0;
      rd(`PTMR_FUNC_ERR_ADDR, rd_val);
      chk("result word", rd_val, err);
      chk("char count", 16'(ptmr_prn_model_inst.got.size()), 16'(exp_q.size()));
      foreach (exp_q[i])
         if (i < ptmr_prn_model_inst.got.size())
            chk("char", {8'h00, ptmr_prn_model_inst.got[i]}, {8'h00, exp_q[i]});
      if (rd_val !== `PTMR_ERR_NONE)
      begin
         wr(`PTMR_FUNC_ERR_ADDR, 16'h0000);
         rd(`PTMR_FUNC_ERR_ADDR, rd_val);
         chk("cleared result", rd_val, 16'h0000);
      end
   endtask : run

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      resetn = 1'b0;
      host_bus = '0;
      print_req = 1'b0;
      slow = 1'b0;
      num_errors = 0;
      total_checks = 0;
      repeat (6) @(posedge clk);
      #1 chk("done in reset", {15'h0000, print_done}, 16'h0000);
      chk("valid in reset", {15'h0000, prn_char.valid}, 16'h0000);
      @(posedge clk);
      resetn <= 1'b1;
      wr(`PTMR_FUNC_SEL_ADDR, `PTMR_FUNC_PRN_TEST);
      rd(`PTMR_FUNC_SEL_ADDR, rd_val);
      chk("select word", rd_val, `PTMR_FUNC_PRN_TEST);
      // Stalling printer and a mid-run select change
      exp_q.delete();
      for (int c = 8'h21; c <= 8'h7E; c++)
         exp_q.push_back(8'(c));
      slow <= 1'b1;
      run(`PTMR_FUNC_PRN_TEST, `PTMR_ERR_NONE, 1'b1);
      slow <= 1'b0;
      exp_q.delete();
      run(16'h0007, `PTMR_ERR_BAD_FUNC, 1'b0);
      put_msg(12'h000, "");
      run(`PTMR_FUNC_TEST_OUT, `PTMR_ERR_NO_MSG, 1'b0);
      wr(`PTMR_FREE_BASE_ADDR, 16'h0051);
      run(`PTMR_FUNC_TEST_OUT, `PTMR_ERR_BAD_LEN, 1'b0);
      put_msg(12'h000, "ABC");
      put_msg(12'h001, "DE");
      put_msg(12'h002, "");
      expect_str("ABCDE");
      run(`PTMR_FUNC_TEST_OUT, `PTMR_ERR_NONE, 1'b0);
      rd(`PTMR_FREE_BASE_ADDR, rd_val);
      chk("count word", rd_val, 16'h0003);
      rd(`PTMR_FREE_BASE_ADDR + 12'h001, rd_val);
      chk("message word", rd_val, 16'h4241);
      rd(`PTMR_FREE_BASE_ADDR + 12'h002, rd_val);
      chk("odd tail word", rd_val, 16'h0043);
      end_of_test();
   end
endmodule : tb

// ===== verilog/ptmr_core.sv
// Printer function engine: printer test and registered message test output
`timescale 1ns/1ps
`include "ptmr_regs.svh"
//Contract
// - Each free message slot holds a character-count word followed by packed message words.
// - Printer test sends codes 21H through 7EH in ascending order.
// - Test output prints the stored messages one by one in increasing number order.
// - The device raises print done on finish and the host then drops the request.
// - On completion a result code sits at 801H, zero for success, else an error.
// - A stored message count lies between 1 and 80 characters.
module ptmr_core (
   input wire logic clk,
   input wire logic resetn,
   input wire ptmr_pkg::ptmr_bus_s host_bus,
   output logic [15:0] host_rdata,
   input wire logic print_req,
   output logic print_done,
   output ptmr_pkg::ptmr_char_s prn_char,
   input wire logic prn_ready
);
   ptmr_pkg::ptmr_state_e state_r;
   logic req_s1_r;
   logic req_s2_r;
   logic req_d_r;
   logic [15:0] func_r;
   logic [15:0] err_r;
   logic [7:0] ch_r;
   logic [4:0] slot_r;
   logic [6:0] left_r;
   logic [11:0] word_r;
   logic hi_r;
   logic rd_wait_r;
   logic [11:0] eng_addr;
   logic [15:0] eng_rdata;
   logic req_rise;
   logic eng_wr;
   logic [15:0] eng_wdata;
   logic mem_wr;
   logic [11:0] mem_addr;
   logic [15:0] mem_wdata;
   logic [15:0] mem_rdata;

   // ************************************************************
   // Request synchroniser, it comes from the host's domain
   // ************************************************************
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         req_s1_r <= 1'b0;
         req_s2_r <= 1'b0;
         req_d_r <= 1'b0;
      end
      else
      begin
         req_s1_r <= print_req;
         req_s2_r <= req_s1_r;
         req_d_r <= req_s2_r;
      end
   end
   assign req_rise = req_s2_r && !req_d_r;

   // Host has priority on port A; the engine only writes the result word
   assign eng_wr = (state_r == ptmr_pkg::PTMR_DONE) && !host_bus.wr;
   assign eng_wdata = err_r;
   assign mem_wr = host_bus.wr || eng_wr;
   // Port A follows the host except in the cycles that store the result
   assign mem_addr = eng_wr ? `PTMR_FUNC_ERR_ADDR : host_bus.addr;
   assign mem_wdata = host_bus.wr ? host_bus.wdata : eng_wdata;
   assign host_rdata = mem_rdata;

   // Slot of message n begins 41 words after slot n-1
   function automatic logic [11:0] slot_addr(input logic [4:0] n);
      slot_addr = `PTMR_FREE_BASE_ADDR + 12'(n) * `PTMR_FREE_SLOT_WORDS;
   endfunction : slot_addr

   ptmr_mem u_mem (
      .clk(clk),
      .a_wr(mem_wr),
      .a_addr(mem_addr),
      .a_wdata(mem_wdata),
      .a_rdata(mem_rdata),
      .b_addr(eng_addr),
      .b_rdata(eng_rdata)
   );

   // Engine read address: function word while idle, else the message walk
   assign eng_addr = (state_r == ptmr_pkg::PTMR_IDLE) ? `PTMR_FUNC_SEL_ADDR : word_r;

   // ************************************************************
   // Operation sequencer
   // ************************************************************
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         state_r <= ptmr_pkg::PTMR_IDLE;
         func_r <= 16'h0000;
         err_r <= `PTMR_ERR_NONE;
         ch_r <= `PTMR_CHAR_FIRST;
         slot_r <= 5'h00;
         left_r <= 7'h00;
         word_r <= `PTMR_FREE_BASE_ADDR;
         hi_r <= 1'b0;
         rd_wait_r <= 1'b0;
         print_done <= 1'b0;
         prn_char <= '0;
      end
      else
      begin
         // Character handed over once the printer takes it
         if (prn_char.valid && prn_ready)
            prn_char.valid <= 1'b0;
         case (state_r)
            ptmr_pkg::PTMR_IDLE:
            begin
               print_done <= 1'b0;
               // Latch the function only at the edge, later writes are ignored
               if (req_rise)
               begin
                  func_r <= eng_rdata;
                  err_r <= `PTMR_ERR_NONE;
                  ch_r <= `PTMR_CHAR_FIRST;
                  slot_r <= 5'h00;
                  word_r <= `PTMR_FREE_BASE_ADDR;
                  rd_wait_r <= 1'b1;
                  if (eng_rdata == `PTMR_FUNC_PRN_TEST)
                     state_r <= ptmr_pkg::PTMR_ASCII;
                  else if (eng_rdata == `PTMR_FUNC_TEST_OUT)
                     state_r <= ptmr_pkg::PTMR_MSG_HDR;
                  else
                  begin
                     err_r <= `PTMR_ERR_BAD_FUNC;
                     state_r <= ptmr_pkg::PTMR_DONE;
                  end
               end
            end
            ptmr_pkg::PTMR_ASCII:
            begin
               // Ascending printable codes
               if (!prn_char.valid || prn_ready)
               begin
                  prn_char.valid <= 1'b1;
                  prn_char.data <= ch_r;
                  if (ch_r == `PTMR_CHAR_LAST)
                     state_r <= ptmr_pkg::PTMR_DONE;
                  else
                     ch_r <= ch_r + 8'h01;
               end
            end
            ptmr_pkg::PTMR_MSG_HDR:
            begin
               // One read cycle latency before the count word is valid
               if (rd_wait_r)
                  rd_wait_r <= 1'b0;
               else if (eng_rdata < `PTMR_MSG_LEN_MIN || eng_rdata > `PTMR_MSG_LEN_MAX)
               begin
                  // Empty or corrupt slot ends the walk
                  if (slot_r == 5'h00)
                     err_r <= (eng_rdata == 16'h0000) ? `PTMR_ERR_NO_MSG : `PTMR_ERR_BAD_LEN;
                  else if (eng_rdata != 16'h0000)
                     err_r <= `PTMR_ERR_BAD_LEN;
                  state_r <= ptmr_pkg::PTMR_DONE;
               end
               else
               begin
                  left_r <= eng_rdata[6:0];
                  word_r <= word_r + 12'h001;
                  hi_r <= 1'b0;
                  rd_wait_r <= 1'b1;
                  state_r <= ptmr_pkg::PTMR_MSG_BODY;
               end
            end
            ptmr_pkg::PTMR_MSG_BODY:
            begin
               // Low byte first, then high byte of each word
               if (rd_wait_r)
                  rd_wait_r <= 1'b0;
               else if (!prn_char.valid || prn_ready)
               begin
                  prn_char.valid <= 1'b1;
                  prn_char.data <= hi_r ? eng_rdata[15:8] : eng_rdata[7:0];
                  left_r <= left_r - 7'h01;
                  hi_r <= !hi_r;
                  if (hi_r)
                  begin
                     word_r <= word_r + 12'h001;
                     rd_wait_r <= 1'b1;
                  end
                  if (left_r == 7'h01)
                  begin
                     // Next message number in increasing order
                     slot_r <= slot_r + 5'h01;
                     word_r <= slot_addr(slot_r + 5'h01);
                     rd_wait_r <= 1'b1;
                     if (slot_r == 5'(`PTMR_FREE_SLOTS - 1))
                        state_r <= ptmr_pkg::PTMR_DONE;
                     else
                        state_r <= ptmr_pkg::PTMR_MSG_HDR;
                  end
               end
            end
            ptmr_pkg::PTMR_DONE:
            begin
               // Result word written no later than the edge that raises done
               if (!host_bus.wr && !prn_char.valid)
               begin
                  print_done <= 1'b1;
                  state_r <= ptmr_pkg::PTMR_IDLE;
               end
            end
            default:
               state_r <= ptmr_pkg::PTMR_IDLE;
         endcase
         // Done holds until the host drops its request
         if (state_r == ptmr_pkg::PTMR_IDLE && print_done && req_s2_r)
            print_done <= 1'b1;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   property p_ascii_range;
      @(posedge clk) disable iff (!resetn)
      (state_r == ptmr_pkg::PTMR_ASCII && prn_char.valid) |->
         (prn_char.data >= `PTMR_CHAR_FIRST && prn_char.data <= `PTMR_CHAR_LAST);
   endproperty
   a_ascii_range: assert property (p_ascii_range) else $error("char out of range");

   property p_ascii_step;
      @(posedge clk) disable iff (!resetn)
      (state_r == ptmr_pkg::PTMR_ASCII && $changed(prn_char.data) && $past(prn_char.valid))
         |-> prn_char.data == $past(prn_char.data) + 8'h01;
   endproperty
   a_ascii_step: assert property (p_ascii_step) else $error("test char not ascending");

   property p_func_held;
      @(posedge clk) disable iff (!resetn)
      (state_r != ptmr_pkg::PTMR_IDLE && $past(state_r) != ptmr_pkg::PTMR_IDLE)
         |-> $stable(func_r) && (state_r != ptmr_pkg::PTMR_ASCII || func_r == `PTMR_FUNC_PRN_TEST);
   endproperty
   a_func_held: assert property (p_func_held) else $error("function changed mid run");

   property p_done_after;
      @(posedge clk) disable iff (!resetn)
      $rose(print_done) |-> $past(state_r) == ptmr_pkg::PTMR_DONE;
   endproperty
   a_done_after: assert property (p_done_after) else $error("done without finish");

   property p_bad_func;
      @(posedge clk) disable iff (!resetn)
      (state_r == ptmr_pkg::PTMR_IDLE && req_rise && eng_rdata != `PTMR_FUNC_PRN_TEST
         && eng_rdata != `PTMR_FUNC_TEST_OUT) |=> err_r == `PTMR_ERR_BAD_FUNC;
   endproperty
   a_bad_func: assert property (p_bad_func) else $error("bad function not flagged");

   property p_len_bound;
      @(posedge clk) disable iff (!resetn)
      (state_r == ptmr_pkg::PTMR_MSG_BODY) |-> (left_r <= 7'h50);
   endproperty
   a_len_bound: assert property (p_len_bound) else $error("count above limit");

   property p_slot_order;
      @(posedge clk) disable iff (!resetn)
      (state_r != ptmr_pkg::PTMR_IDLE && $past(state_r) != ptmr_pkg::PTMR_IDLE && $changed(slot_r))
         |-> slot_r == $past(slot_r) + 5'h01;
   endproperty
   a_slot_order: assert property (p_slot_order) else $error("slot skipped");

   property p_err_written;
      @(posedge clk) disable iff (!resetn)
      $rose(print_done) |-> u_mem.mem[`PTMR_FUNC_ERR_ADDR] == err_r;
   endproperty
   a_err_written: assert property (p_err_written) else $error("result not at error word");
endmodule : ptmr_core

// ===== verilog/ptmr_mem.sv
// Word-wide buffer memory shared by the host and the printer engine
`timescale 1ns/1ps
`include "ptmr_regs.svh"
module ptmr_mem #(
   parameter int DEPTH = 4096
) (
   input wire logic clk,
   input wire logic a_wr,
   input wire logic [11:0] a_addr,
   input wire logic [15:0] a_wdata,
   output logic [15:0] a_rdata,
   input wire logic [11:0] b_addr,
   output logic [15:0] b_rdata
);
   logic [15:0] mem [0:DEPTH-1];

   // ************************************************************
   // Host port writes, both ports read one cycle later
   // ************************************************************
   always_ff @(posedge clk)
   begin
      if (a_wr)
         mem[a_addr] <= a_wdata;
      a_rdata <= mem[a_addr];
      b_rdata <= mem[b_addr];
   end
endmodule : ptmr_mem
